// ==== core/image_port_pkg.sv ====
`default_nettype none
package image_port_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 16;
  localparam int FIFO_DEPTH = 16;
  localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] LINE_PITCH_RST = 16'h0100;
  localparam logic [ADDR_W-1:0] ODD_FIELD_BASE = 16'h8000;
  localparam int SEL_BIT = 0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic oddField;
  } mem_word_s;

  typedef struct packed {
    logic [2:0] strobeSync;
    logic [2:0] frameSync;
    logic [2:0] lineSync;
    logic strobeLvl;
    logic frameLvl;
    logic lineLvl;
    logic [DATA_W-1:0] dataHold;
    logic maskHold;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] lineStart;
    logic oddField;
    logic wrPend;
  } port_state_s;
endpackage : image_port_pkg
`default_nettype wire

// ==== core/image_fifo.sv ====
`default_nettype none
module image_fifo
  import image_port_pkg::*;
#(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH) $error("image_fifo: DEPTH must be a power of two >= 2");
  end

  typedef struct packed {
    logic [PW:0] wrPtr;
    logic [PW:0] rdPtr;
  } fifo_state_s;

  fifo_state_s st_r;
  fifo_state_s st_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full;
  logic empty;

  assign full = (st_r.wrPtr[PW] != st_r.rdPtr[PW]) && (st_r.wrPtr[PW-1:0] == st_r.rdPtr[PW-1:0]);
  assign empty = st_r.wrPtr == st_r.rdPtr;
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[st_r.rdPtr[PW-1:0]];

  always_comb begin
    st_nxt = st_r;
    if (inValid && !full) begin
      st_nxt.wrPtr = st_r.wrPtr + 1'b1;
    end
    if (outReady && !empty) begin
      st_nxt.rdPtr = st_r.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Storage needs no reset; only the pointers define contents
  always_ff @(posedge mclk) begin
    if (inValid && !full) begin
      mem[st_r.wrPtr[PW-1:0]] <= inData;
    end
  end
endmodule : image_fifo
`default_nettype wire

// ==== core/image_port_capture.sv ====
`default_nettype none
// Contract
// - One configuration bit (index F7, bit 0) selects image port or other use of the pins.
// - With the port selected, the eight data lines are inputs from the image device.
// - A low mask discards the byte but still steps the address sequencer by one.
// - A high mask stores the byte into display memory at the sequencer address.
// - Data and mask are captured on the rising edge of the active-low write strobe.
// - Ready is asserted when another byte can be taken; the source pulses the strobe only then.
// - A rising frame sync starts a new frame and restarts frame addressing.
// - A rising line sync starts a new line and moves to the next line start.
// - In interlaced transfers the odd-field input tells odd from even field data.
// - An active-low command output decodes host accesses to external mapped registers; the code asserts it only while the image port is selected.
module image_port_capture
  import image_port_pkg::*;
#(
  parameter int FIFO_WORDS = FIFO_DEPTH,
  parameter logic [ADDR_W-1:0] LINE_PITCH = LINE_PITCH_RST
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Configuration, index F7 register value
  input wire logic [7:0] imagePortIndexGroup,
  // Host decode of external mapped registers
  input wire logic hostExtRegAccess,
  // Image port pins, data lines split into in/out/enable
  input wire logic [DATA_W-1:0] imageByteIn,
  output logic [DATA_W-1:0] imageByteOut,
  output logic imageByteOe,
  input wire logic byteAcceptMask,
  input wire logic externalWriteStrobe_n,
  input wire logic frameSyncIn,
  input wire logic lineSyncIn,
  input wire logic oddFieldIn,
  output logic portReadyOut,
  output logic externalCommand_n,
  // Display memory write port
  output logic memWrValid,
  input wire logic memWrReady,
  output logic [ADDR_W-1:0] memWrAddr,
  output logic [DATA_W-1:0] memWrData
);
  initial begin
    if (FIFO_WORDS < 2) $error("image_port_capture: FIFO_WORDS too small");
  end

  localparam int WORD_W = $bits(mem_word_s);

  port_state_s st_r;
  port_state_s st_nxt;
  logic portSel;
  logic fifoInReady;
  logic fifoOutValid;
  logic [WORD_W-1:0] fifoOutData;
  mem_word_s fifoIn;
  mem_word_s fifoOut;
  logic strobeRise;
  logic frameRise;
  logic lineRise;

  assign portSel = imagePortIndexGroup[SEL_BIT];

  // Lines are never driven by this block while it owns them
  assign imageByteOut = '0;
  assign imageByteOe = 1'b0;

  // Only stages two and three are compared; stage one may be metastable
  assign strobeRise = (st_r.strobeSync[1] == st_r.strobeSync[2]) &&
                      st_r.strobeSync[2] && !st_r.strobeLvl;
  assign frameRise = (st_r.frameSync[1] == st_r.frameSync[2]) &&
                     st_r.frameSync[2] && !st_r.frameLvl;
  assign lineRise = (st_r.lineSync[1] == st_r.lineSync[2]) &&
                    st_r.lineSync[2] && !st_r.lineLvl;

  // Ready drops while a byte waits for the buffer, giving back-pressure
  assign portReadyOut = portSel && !st_r.wrPend && fifoInReady;

  assign externalCommand_n = !(portSel && hostExtRegAccess);

  always_comb begin
    st_nxt = st_r;
    st_nxt.strobeSync = {st_r.strobeSync[1:0], !externalWriteStrobe_n};
    st_nxt.frameSync = {st_r.frameSync[1:0], frameSyncIn};
    st_nxt.lineSync = {st_r.lineSync[1:0], lineSyncIn};
    if (st_r.strobeSync[1] == st_r.strobeSync[2]) begin
      st_nxt.strobeLvl = st_r.strobeSync[2];
    end
    if (st_r.frameSync[1] == st_r.frameSync[2]) begin
      st_nxt.frameLvl = st_r.frameSync[2];
    end
    if (st_r.lineSync[1] == st_r.lineSync[2]) begin
      st_nxt.lineLvl = st_r.lineSync[2];
    end
    // Strobe synchronised as active-high "low level seen"; its fall marks the pin's rise
    if (portSel && !strobeRise && st_r.strobeLvl &&
        (st_r.strobeSync[1] == st_r.strobeSync[2]) && !st_r.strobeSync[2]) begin
      // Pin data has been stable since before the rising edge, sample it now
      st_nxt.dataHold = imageByteIn;
      st_nxt.maskHold = byteAcceptMask;
      st_nxt.wrPend = 1'b1;
    end else if (st_r.wrPend) begin
      if (!st_r.maskHold) begin
        st_nxt.addr = st_r.addr + 1'b1;
        st_nxt.wrPend = 1'b0;
      end else if (fifoInReady) begin
        st_nxt.addr = st_r.addr + 1'b1;
        st_nxt.wrPend = 1'b0;
      end
    end
    if (portSel && frameRise) begin
      st_nxt.oddField = oddFieldIn;
      st_nxt.addr = oddFieldIn ? ODD_FIELD_BASE : ADDR_RST;
      st_nxt.lineStart = oddFieldIn ? ODD_FIELD_BASE : ADDR_RST;
    end else if (portSel && lineRise) begin
      st_nxt.addr = st_r.lineStart + LINE_PITCH;
      st_nxt.lineStart = st_r.lineStart + LINE_PITCH;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    fifoIn.addr = st_r.addr;
    fifoIn.data = st_r.dataHold;
    fifoIn.oddField = st_r.oddField;
  end

  image_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_WORDS)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .inValid(st_r.wrPend && st_r.maskHold),
    .inReady(fifoInReady),
    .inData(fifoIn),
    .outValid(fifoOutValid),
    .outReady(memWrReady),
    .outData(fifoOutData)
  );

  assign fifoOut = mem_word_s'(fifoOutData);
  assign memWrValid = fifoOutValid;
  assign memWrAddr = fifoOut.addr;
  assign memWrData = fifoOut.data;
endmodule : image_port_capture
`default_nettype wire

// ==== tb/image_port_capture_asserts.sv ====
`default_nettype none
module image_port_capture_asserts (
  // Watched ports
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] imagePortIndexGroup,
  input wire logic hostExtRegAccess,
  input wire logic externalWriteStrobe_n,
  input wire logic imageByteOe,
  input wire logic portReadyOut,
  input wire logic externalCommand_n,
  input wire logic memWrValid,
  input wire logic memWrReady,
  input wire logic [15:0] memWrAddr
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire sel = imagePortIndexGroup[0];
  // The strobe edge crosses three sync stages, so ready cannot drop at once
  sequence takeSeen; portReadyOut [*2] ##[1:5] !portReadyOut; endsequence
  sequence offLong; !sel [*6]; endsequence
  a_pins_input: assert property (!imageByteOe)
    else $error("pins driven");
  a_cmd_decode: assert property (externalCommand_n == !(sel && hostExtRegAccess))
    else $error("bad command");
  a_ready_sel: assert property (!sel |-> !portReadyOut)
    else $error("ready off port");
  a_take_timing: assert property ($rose(externalWriteStrobe_n) && sel && portReadyOut |-> takeSeen)
    else $error("take timing");
  a_ready_back: assert property ($fell(portReadyOut) && sel && memWrReady |-> ##[1:3] portReadyOut)
    else $error("ready stuck");
  a_mem_stands: assert property (memWrValid && !memWrReady |=> memWrValid && $stable(memWrAddr))
    else $error("word dropped");
  a_write_cause: assert property ($rose(memWrValid) |-> !$past(portReadyOut))
    else $error("write no strobe");
  a_off_quiet: assert property (offLong |-> !$rose(memWrValid))
    else $error("write when off");
endmodule : image_port_capture_asserts
bind image_port_capture image_port_capture_asserts chk_u (.mclk, .sys_rst, .imagePortIndexGroup,
  .hostExtRegAccess, .externalWriteStrobe_n, .imageByteOe, .portReadyOut, .externalCommand_n,
  .memWrValid, .memWrReady, .memWrAddr);
`default_nettype wire

// ==== tb/image_source_model.sv ====
`default_nettype none
module image_source_model (
  // Clock
  input wire logic mclk,
  // Image port pins
  input wire logic portReadyOut,
  output logic [7:0] imageByteIn,
  output logic byteAcceptMask,
  output logic externalWriteStrobe_n,
  output logic frameSyncIn,
  output logic lineSyncIn,
  output logic oddFieldIn,
  output int missed
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] rdy = 2'b00;
  always @(posedge mclk) rdy <= {rdy[0], portReadyOut};
  initial begin
    {imageByteIn, byteAcceptMask, externalWriteStrobe_n} = 10'h3ff;
    {frameSyncIn, lineSyncIn, oddFieldIn} = 3'b000;
    missed = 0;
  end
  task automatic send(input logic [7:0] d, input logic m);
    int n;
    for (n = 0; n < 300 && rdy[1] !== 1'b1; n++) @(negedge mclk);
    if (n == 300) missed++;
    @(negedge mclk);
    {imageByteIn, byteAcceptMask, externalWriteStrobe_n} = {d, m, 1'b0};
    repeat (4) @(negedge mclk);
    externalWriteStrobe_n = 1'b1;
    repeat (6) @(negedge mclk);
    // Released pins float to the pull-up level
    {imageByteIn, byteAcceptMask} = 9'h1ff;
  endtask : send
  task automatic pulse(input logic fr, input logic odd);
    @(negedge mclk);
    oddFieldIn = odd;
    {frameSyncIn, lineSyncIn} = {fr, !fr};
    repeat (4) @(negedge mclk);
    {frameSyncIn, lineSyncIn} = 2'b00;
    repeat (4) @(negedge mclk);
  endtask : pulse
endmodule : image_source_model
`default_nettype wire

// ==== tb/image_port_capture_tb.sv ====
`default_nettype none
module image_port_capture_tb;
  import image_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] grp = 8'h00;
  logic host = 1'b1;
  logic memWrReady = 1'b1;
  logic [7:0] imageByteIn, imageByteOut, memWrData;
  logic [15:0] memWrAddr;
  logic byteAcceptMask, externalWriteStrobe_n, frameSyncIn, lineSyncIn, oddFieldIn;
  logic imageByteOe, portReadyOut, externalCommand_n, memWrValid;
  int failures = 0;
  int num_checks = 0;
  int missed;
  logic [23:0] seen[$];
  `define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
  initial forever #50 mclk = ~mclk;
  image_port_capture dut_u (.mclk, .sys_rst, .imagePortIndexGroup(grp), .hostExtRegAccess(host),
    .imageByteIn, .imageByteOut, .imageByteOe, .byteAcceptMask, .externalWriteStrobe_n,
    .frameSyncIn, .lineSyncIn, .oddFieldIn, .portReadyOut, .externalCommand_n, .memWrValid,
    .memWrReady, .memWrAddr, .memWrData);
  image_source_model src_u (.mclk, .portReadyOut, .imageByteIn, .byteAcceptMask,
    .externalWriteStrobe_n, .frameSyncIn, .lineSyncIn, .oddFieldIn, .missed);
  always @(posedge mclk) if (!sys_rst && memWrValid === 1'b1 && memWrReady) begin
    seen.push_back({memWrAddr, memWrData});
  end
  task automatic word(input logic [15:0] a, input logic [7:0] d);
    for (int n = 0; n < 200 && seen.size() == 0; n++) @(negedge mclk);
    `CHK("word", {a, d}, (seen.size() ? seen.pop_front() : 24'hxxxxxx))
  endtask : word
  task automatic t_select;
    `CHK("ready", 1'b0, portReadyOut)
    `CHK("command", 1'b1, externalCommand_n)
    grp = 8'h01;
    @(negedge mclk);
    `CHK("command", 1'b0, externalCommand_n)
    `CHK("data oe", 1'b0, imageByteOe)
    `CHK("data out", 8'h00, imageByteOut)
    host = 1'b0;
  endtask : t_select
  task automatic t_frame_line;
    src_u.pulse(1'b1, 1'b0);
    src_u.send(8'h11, 1'b1);
    src_u.send(8'h22, 1'b0);
    src_u.send(8'h33, 1'b1);
    src_u.pulse(1'b0, 1'b0);
    src_u.send(8'h44, 1'b1);
    word(16'h0000, 8'h11);
    word(16'h0002, 8'h33);
    word(LINE_PITCH_RST, 8'h44);
  endtask : t_frame_line
  task automatic t_odd_fill;
    src_u.pulse(1'b1, 1'b1);
    memWrReady = 1'b0;
    for (int i = 0; i < 16; i++) src_u.send(8'(i), 1'b1);
    repeat (10) @(negedge mclk);
    `CHK("ready full", 1'b0, portReadyOut)
    memWrReady = 1'b1;
    for (int i = 0; i < 16; i++) word(ODD_FIELD_BASE + 16'(i), 8'(i));
    `CHK("valid", 1'b0, memWrValid)
  endtask : t_odd_fill
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  initial begin
    repeat (4) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_select();
    t_frame_line();
    t_odd_fill();
    `CHK("stalls", 0, missed)
    conclude();
  end
  initial begin
    #(100 * 5000);
    failures++;
    conclude();
  end
endmodule : image_port_capture_tb
`default_nettype wire
